/* File: siu_pkg.sv */
// shared constants and types for the subtract instruction unit
package siu_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] SIU_OFS_INSTR = 12'h000;
    localparam logic [11:0] SIU_OFS_ACC = 12'h004;
    localparam logic [11:0] SIU_OFS_STATUS = 12'h008;
    localparam logic [11:0] SIU_OFS_DMEM = 12'h200;
    localparam int SIU_DMEM_DEPTH = 128;

    // ------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------
    localparam int SIU_ST_CARRY = 0;
    localparam int SIU_ST_DIGIT = 1;
    localparam int SIU_ST_ZERO = 2;
    localparam int SIU_ST_IGNORED = 3;
    localparam logic [7:0] SIU_ACC_RST = 8'h00;
    localparam logic [13:0] SIU_INSTR_RST = 14'h0000;

    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam logic [1:0] SIU_LIT_TOP = 2'h3;
    localparam logic [2:0] SIU_LIT_SUB = 3'h6;
    localparam logic [5:0] SIU_REG_OP = 6'h02;
    localparam int SIU_DEST_BIT = 7;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] SIU_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIU_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SIU_SEL_INSTR,
        SIU_SEL_ACC,
        SIU_SEL_STATUS,
        SIU_SEL_DMEM,
        SIU_SEL_NONE
    } siu_sel_t;

    typedef struct packed {
        logic [7:0] diff;
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } siu_alu_out_t;

endpackage

/* File: siu_props.sv */
// bus-port assertions for the subtract instruction unit
`timescale 1ns/1ps
module siu_props
    import siu_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // remembers which word the pending read answer belongs to
    logic [11:0] rd_addr_r;
    logic [11:0] rd_addr_nxt;
    always_comb begin
        rd_addr_nxt = rd_addr_r;
        if (arvalid && arready) begin
            rd_addr_nxt = araddr[11:0];
        end
    end
    always_ff @(posedge aclk) begin
        rd_addr_r <= aresetn ? rd_addr_nxt : 12'h000;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_write_one_cycle: assert property (
        awvalid && awready && wvalid && wready && !bvalid
        |=> !awready && !wready && !bvalid ##1 bvalid)
        else $error("write answer not one cycle after execution");
    a_read_one_cycle: assert property (
        arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    a_read_blocks_ar: assert property (
        rvalid |-> !arready)
        else $error("read accepted while answer pending");
    a_bresp_readies: assert property (
        $rose(bvalid) |-> awready && wready)
        else $error("write holders not freed with answer");
    a_acc_byte_wide: assert property (
        rvalid && rd_addr_r == SIU_OFS_ACC
        |-> rdata[31:8] == 24'h0 && rresp == SIU_RESP_OKAY)
        else $error("accumulator read wider than a byte");
    a_status_nibble: assert property (
        rvalid && rd_addr_r == SIU_OFS_STATUS
        |-> rdata[31:4] == 28'h0)
        else $error("status read has stray bits");
    a_zero_gives_carry: assert property (
        rvalid && rd_addr_r == SIU_OFS_STATUS && rdata[SIU_ST_ZERO]
        |-> rdata[SIU_ST_CARRY] && rdata[SIU_ST_DIGIT])
        else $error("zero result without carry");
    a_dmem_byte_wide: assert property (
        rvalid && rd_addr_r[11:9] == 3'h1 && rd_addr_r[1:0] == 2'h0
        |-> rdata[31:8] == 24'h0)
        else $error("data register read wider than a byte");
    a_unaligned_err: assert property (
        rvalid && rd_addr_r[1:0] != 2'h0
        |-> rresp == SIU_RESP_SLVERR && rdata == 32'h0)
        else $error("unaligned read not refused");
endmodule // siu_props

/* File: siu_sub_alu.sv */
// 8-bit subtractor producing difference and status flags
`timescale 1ns/1ps
module siu_sub_alu (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output siu_pkg::siu_alu_out_t result
);
    import siu_pkg::*;

    always_comb begin
        // two's complement: wraps when the subtrahend is larger
        result.diff = minuend - subtrahend;
        // carry is an inverted borrow
        result.carry = (minuend >= subtrahend);
        result.digit_carry_flag = (minuend[3:0] >= subtrahend[3:0]);
        result.zero = (result.diff == 8'h00);
    end

endmodule // siu_sub_alu

/* File: siu_top.sv */
// subtract instruction unit with an AXI4-Lite register slave
// Operation
// - literal minus accumulator, literal 0 to 255
// - decode 11 110x opcode, result into accumulator
// - register minus accumulator, opcode 00 0010
// - destination bit picks accumulator or register
// - carry set when minuend exceeds subtrahend
// - carry set when operands are equal
// - carry cleared on borrow, wrapped result kept
`timescale 1ns/1ps
module siu_top #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import siu_pkg::*;

    if (ADDR_W < 12) begin : g_chk
        $error("siu_top: ADDR_W must be at least 12");
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // only the low 12 bits are decoded; higher bits alias the map
    function automatic siu_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [11:0] lo;
        lo = a[11:0];
        if (lo[1:0] != 2'h0) begin
            decode = SIU_SEL_NONE;
        end else if (lo == SIU_OFS_INSTR) begin
            decode = SIU_SEL_INSTR;
        end else if (lo == SIU_OFS_ACC) begin
            decode = SIU_SEL_ACC;
        end else if (lo == SIU_OFS_STATUS) begin
            decode = SIU_SEL_STATUS;
        end else if (lo[11:9] == SIU_OFS_DMEM[11:9]) begin
            decode = SIU_SEL_DMEM;
        end else begin
            decode = SIU_SEL_NONE;
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] dmem [SIU_DMEM_DEPTH];
    logic [7:0] acc_r, acc_nxt;
    logic carry_r, carry_nxt;
    logic digit_r, digit_nxt;
    logic zero_r, zero_nxt;
    logic ignored_r, ignored_nxt;
    logic [13:0] instr_r, instr_nxt;
    logic aw_full_r, aw_full_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic w_full_r, w_full_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;

    // ------------------------------------------------------------
    // instruction decode and datapath
    // ------------------------------------------------------------
    logic [13:0] op;
    logic is_lit;
    logic is_reg;
    logic [6:0] op_f;
    logic [7:0] minuend;
    siu_alu_out_t alu;

    assign op = wdata_r[13:0];
    // bit 8 of the literal form is a don't-care
    assign is_lit = (op[13:12] == SIU_LIT_TOP) &&
                    (op[11:9] == SIU_LIT_SUB);
    assign is_reg = (op[13:8] == SIU_REG_OP);
    assign op_f = op[6:0];
    assign minuend = is_lit ? op[7:0] : dmem[op_f];

    siu_sub_alu u_alu (
        .minuend(minuend),
        .subtrahend(acc_r),
        .result(alu)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        siu_sel_t rsel;
        siu_sel_t wsel;
        rsel = decode(araddr);
        wsel = decode(awaddr_r);
        acc_nxt = acc_r;
        carry_nxt = carry_r;
        digit_nxt = digit_r;
        zero_nxt = zero_r;
        ignored_nxt = ignored_r;
        instr_nxt = instr_r;
        aw_full_nxt = aw_full_r;
        awaddr_nxt = awaddr_r;
        w_full_nxt = w_full_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        mem_we = 1'b0;
        mem_waddr = 7'h00;
        mem_wdata = 8'h00;

        // read channel: answer one cycle after the address is taken
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = SIU_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (rsel)
                SIU_SEL_INSTR: rdata_nxt[13:0] = instr_r;
                SIU_SEL_ACC: rdata_nxt[7:0] = acc_r;
                SIU_SEL_STATUS: begin
                    rdata_nxt[SIU_ST_CARRY] = carry_r;
                    rdata_nxt[SIU_ST_DIGIT] = digit_r;
                    rdata_nxt[SIU_ST_ZERO] = zero_r;
                    rdata_nxt[SIU_ST_IGNORED] = ignored_r;
                end
                SIU_SEL_DMEM: rdata_nxt[7:0] = dmem[araddr[8:2]];
                default: rresp_nxt = SIU_RESP_SLVERR;
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end

        // write channels are taken independently, in either order
        if (awvalid && awready_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && wready_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end

        if (aw_full_r && w_full_r && !bvalid_r) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = SIU_RESP_OKAY;
            case (wsel)
                SIU_SEL_INSTR: begin
                    // a partial opcode write would execute garbage
                    if (wstrb_r[1:0] == 2'h3) begin
                        instr_nxt = op;
                        ignored_nxt = !(is_lit || is_reg);
                        if (is_lit || is_reg) begin
                            carry_nxt = alu.carry;
                            digit_nxt = alu.digit_carry_flag;
                            zero_nxt = alu.zero;
                        end
                        if (is_lit || (is_reg && !op[SIU_DEST_BIT])) begin
                            acc_nxt = alu.diff;
                        end
                        if (is_reg && op[SIU_DEST_BIT]) begin
                            mem_we = 1'b1;
                            mem_waddr = op_f;
                            mem_wdata = alu.diff;
                        end
                    end
                end
                SIU_SEL_ACC: begin
                    if (wstrb_r[0]) begin
                        acc_nxt = wdata_r[7:0];
                    end
                end
                SIU_SEL_STATUS: begin
                    if (wstrb_r[0]) begin
                        carry_nxt = wdata_r[SIU_ST_CARRY];
                        digit_nxt = wdata_r[SIU_ST_DIGIT];
                        zero_nxt = wdata_r[SIU_ST_ZERO];
                    end
                end
                SIU_SEL_DMEM: begin
                    if (wstrb_r[0]) begin
                        mem_we = 1'b1;
                        mem_waddr = awaddr_r[8:2];
                        mem_wdata = wdata_r[7:0];
                    end
                end
                default: bresp_nxt = SIU_RESP_SLVERR;
            endcase
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end

        awready_nxt = !aw_full_nxt;
        wready_nxt = !w_full_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= SIU_ACC_RST;
            carry_r <= 1'b0;
            digit_r <= 1'b0;
            zero_r <= 1'b0;
            ignored_r <= 1'b0;
            instr_r <= SIU_INSTR_RST;
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
            w_full_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= SIU_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= SIU_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            acc_r <= acc_nxt;
            carry_r <= carry_nxt;
            digit_r <= digit_nxt;
            zero_r <= zero_nxt;
            ignored_r <= ignored_nxt;
            instr_r <= instr_nxt;
            aw_full_r <= aw_full_nxt;
            awaddr_r <= awaddr_nxt;
            w_full_r <= w_full_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // data memory stands in for the core register file
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SIU_DMEM_DEPTH; i++) begin
                dmem[i] <= 8'h00;
            end
        end else if (mem_we) begin
            dmem[mem_waddr] <= mem_wdata;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

endmodule // siu_top

/* File: subtract_instruction_unit_test.sv */
// self-checking bench for the subtract instruction unit
`timescale 1ns/1ps
module subtract_instruction_unit_test;
    import siu_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_mismatch = 0;
    int compares = 0;

    siu_top #(.ADDR_W(12)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        n_mismatch++;
        $display("[FAIL] %0t bus answer never came", $time);
        final_report();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    // {ignored, zero, digit carry, carry, difference}
    function automatic logic [11:0] ref_sub(input logic [7:0] m,
                                            input logic [7:0] s);
        logic [7:0] diff;
        diff = m - s;
        return {1'b0, diff == 8'h00, m[3:0] >= s[3:0], m >= s, diff};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_literal();
        logic [7:0] ks[6] = '{8'h02, 8'h02, 8'h02, 8'hff, 8'h00, 8'h10};
        logic [7:0] as[6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'hff, 8'h01};
        logic [11:0] e;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            e = ref_sub(ks[i], as[i]);
            wr(SIU_OFS_ACC, {24'h0, as[i]}, r);
            // the don't-care opcode bit is toggled across the table
            wr(SIU_OFS_INSTR,
               {18'h0, SIU_LIT_TOP, SIU_LIT_SUB, i[0], ks[i]}, r);
            rd(SIU_OFS_ACC, d, r);
            check(d, {24'h0, e[7:0]});
            rd(SIU_OFS_STATUS, d, r);
            check(d, {28'h0, e[11:8]});
        end
    endtask

    task automatic t_register();
        logic [6:0] fs[4] = '{7'h00, 7'h7f, 7'h05, 7'h7f};
        logic [7:0] ms[4] = '{8'h03, 8'h02, 8'h01, 8'h80};
        logic [7:0] as[4] = '{8'h02, 8'h02, 8'h02, 8'h81};
        logic [11:0] e, fa;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            fa = SIU_OFS_DMEM + {3'h0, fs[i], 2'h0};
            e = ref_sub(ms[i], as[i]);
            wr(fa, {24'h0, ms[i]}, r);
            wr(SIU_OFS_ACC, {24'h0, as[i]}, r);
            wr(SIU_OFS_INSTR, {18'h0, SIU_REG_OP, ~i[0], fs[i]}, r);
            rd(SIU_OFS_ACC, d, r);
            check(d, {24'h0, i[0] ? e[7:0] : as[i]});
            rd(fa, d, r);
            check(d, {24'h0, i[0] ? ms[i] : e[7:0]});
            rd(SIU_OFS_STATUS, d, r);
            check(d, {28'h0, e[11:8]});
        end
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        rd(12'h00c, d, r);
        check({30'h0, r}, {30'h0, SIU_RESP_SLVERR});
        check(d, 32'h0);
        rd(12'h201, d, r);
        check({30'h0, r}, {30'h0, SIU_RESP_SLVERR});
        wr(12'h100, 32'h0000005a, r);
        check({30'h0, r}, {30'h0, SIU_RESP_SLVERR});
    endtask

    task automatic t_other();
        logic [31:0] d;
        logic [1:0] r;
        wr(SIU_OFS_ACC, 32'h0000_0005, r);
        wr(SIU_OFS_STATUS, 32'h0000_0003, r);
        check({30'h0, r}, {30'h0, SIU_RESP_OKAY});
        // a neighbouring literal opcode (11 1010) must not subtract
        wr(SIU_OFS_INSTR, 32'h0000_3a40, r);
        check({30'h0, r}, {30'h0, SIU_RESP_OKAY});
        rd(SIU_OFS_ACC, d, r);
        check({30'h0, r}, {30'h0, SIU_RESP_OKAY});
        check(d, 32'h0000_0005);
        rd(SIU_OFS_STATUS, d, r);
        check(d, 32'h0000_000b);
        rd(SIU_OFS_INSTR, d, r);
        check(d, 32'h0000_3a40);
        // an opcode written without both low byte lanes is dropped
        wstrb <= 4'h1;
        wr(SIU_OFS_INSTR, 32'h0000_3c07, r);
        wstrb <= 4'hf;
        check({30'h0, r}, {30'h0, SIU_RESP_OKAY});
        rd(SIU_OFS_ACC, d, r);
        check(d, 32'h0000_0005);
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_literal();
        t_register();
        t_unmapped();
        t_other();
        final_report();
    end
endmodule // subtract_instruction_unit_test

bind siu_top siu_props #(.ADDR_W(ADDR_W)) u_props (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);
